// ---- include/pmr_pkg.sv ----
// constants and types for the single-word pci read master
// assumes one 10 mhz clock shared by the pci pins and the local side
package pmr_pkg;
	// ********************************************************
	// widths
	// ********************************************************
	localparam int PMR_AD_W = 32; // pci address/data width
	localparam int PMR_CBE_W = 4; // command / byte enable width
	localparam int PMR_LEN_W = 8; // burst length width
	localparam int PMR_FIFO_DEPTH = 8; // read word buffer depth

	// ********************************************************
	// local master state codes
	// ********************************************************
	localparam logic [3:0] PMR_ST_TERM = 4'h0; // bus termination
	localparam logic [3:0] PMR_ST_LOAD = 4'h1; // address loading
	localparam logic [3:0] PMR_ST_XFER = 4'h2; // bus transaction

	// ********************************************************
	// termination reasons
	// ********************************************************
	localparam logic [1:0] PMR_TERM_NONE = 2'h0; // nothing yet
	localparam logic [1:0] PMR_TERM_NORMAL = 2'h1; // normal end

	// latched request: address, command, burst length
	typedef struct packed {
		logic [PMR_AD_W-1:0] addr;
		logic [PMR_CBE_W-1:0] cmd;
		logic [PMR_LEN_W-1:0] len;
	} pmr_req_t;

	// sequencer states
	typedef enum logic [3:0] {
		PMR_IDLE,
		PMR_REQ,
		PMR_GRANT,
		PMR_LOAD,
		PMR_ADDR,
		PMR_TURN,
		PMR_DATA,
		PMR_TEND
	} pmr_state_t;
endpackage

// ---- core/pmr_master.sv ----
// pci master single read core with its read word buffer
// assumes pci pins are synchronous to clk_sys_i and the pad logic
// resolves each pin from the _o / _oe pairs given here
`timescale 1ns/10ps

// ************************************************************
// read word buffer
// ************************************************************
module pmr_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 8
) (
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [WIDTH-1:0] in_data_i,
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [WIDTH-1:0] out_data_o
);
	localparam int PW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH]; // storage flops
	logic [PW-1:0] wr_ptr; // next slot to write
	logic [PW-1:0] rd_ptr; // oldest word
	logic [PW:0] count; // words held
	logic push; // word taken in
	logic pop; // word handed out

	assign in_ready_o = (count != DEPTH[PW:0]);
	assign out_valid_o = (count != '0);
	assign out_data_o = mem[rd_ptr];
	assign push = in_valid_i & in_ready_o;
	assign pop = out_valid_o & out_ready_i;

	// storage write, no reset needed on data
	always_ff @(posedge clk_sys_i) begin
		if (push) begin
			mem[wr_ptr] <= in_data_i;
		end
	end

	// pointers and fill count
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end else begin
			if (push) begin
				wr_ptr <= (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
			end
			// simultaneous push and pop keeps the count
			if (push & ~pop) begin
				count <= count + 1'b1;
			end else if (pop & ~push) begin
				count <= count - 1'b1;
			end
		end
	end
endmodule

// ************************************************************
// master sequencer
// ************************************************************
module pmr_master
	import pmr_pkg::*;
#(
	parameter int LEN_W = PMR_LEN_W,
	parameter int DEPTH = PMR_FIFO_DEPTH
) (
	input wire logic clk_sys_i,
	input wire logic rst_i,
	// local master side
	input wire logic local_req_single_width_n_i,
	input wire logic [PMR_AD_W-1:0] local_addr_data_in_i,
	input wire logic [PMR_CBE_W-1:0] local_cmd_byteen_in_i,
	input wire logic [LEN_W-1:0] local_burst_len_in_i,
	input wire logic local_master_ready_n_i,
	output logic local_grant_n_o,
	output logic [3:0] local_master_state_o,
	output logic [1:0] local_term_reason_o,
	output logic [LEN_W-1:0] local_burst_counter_o,
	output logic [PMR_AD_W-1:0] local_read_bus_out_o,
	output logic local_xfer_strobe_n_o,
	// pci side
	output logic reqn_o,
	input wire logic gntn_i,
	input wire logic framen_i,
	output logic framen_o,
	output logic framen_oe_o,
	input wire logic irdyn_i,
	output logic irdyn_o,
	output logic irdyn_oe_o,
	input wire logic trdyn_i,
	input wire logic devseln_i,
	input wire logic [PMR_AD_W-1:0] ad_i,
	output logic [PMR_AD_W-1:0] ad_o,
	output logic ad_oe_o,
	output logic [PMR_CBE_W-1:0] cben_o,
	output logic cben_oe_o
);
	// ********************************************************
	// declarations
	// ********************************************************
	pmr_state_t state; // sequencer state
	pmr_req_t req_lat; // latched request
	logic req_on; // local request asserted (active low pin)
	logic ready_on; // local ready asserted (active low pin)
	logic bus_idle; // no frame and no irdy on the bus
	logic phase_done; // data state with trdyn and devseln both low
	logic fifo_ready; // buffer has room
	logic fifo_valid; // buffer holds a word
	logic [PMR_CBE_W-1:0] byteen; // byte enables for the data phase

	assign req_on = ~local_req_single_width_n_i;
	assign ready_on = ~local_master_ready_n_i;
	assign bus_idle = framen_i & irdyn_i;
	// completion only counts while this core drives irdyn and the
	// target has claimed the cycle, so a stray trdyn cannot end it
	assign phase_done = (state == PMR_DATA) & ~trdyn_i & ~devseln_i;

	// ********************************************************
	// sequencer
	// ********************************************************
	// one step per pci clock through request, address, data
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			state <= PMR_IDLE;
		end else begin
			case (state)
				PMR_IDLE: begin
					// new request only accepted from termination
					if (req_on) begin
						state <= PMR_REQ;
					end
				end
				PMR_REQ: begin
					// wait for grant with the bus free
					if (~gntn_i & bus_idle) begin
						state <= PMR_GRANT;
					end
				end
				PMR_GRANT: begin
					if (req_on & ~gntn_i) begin
						state <= PMR_LOAD;
					end else if (gntn_i) begin
						state <= PMR_REQ; // grant lost, ask again
					end
				end
				PMR_LOAD: begin
					state <= PMR_ADDR;
				end
				PMR_ADDR: begin
					state <= PMR_TURN;
				end
				PMR_TURN: begin
					// stall until local ready seen and room for the word
					if (ready_on & fifo_ready) begin
						state <= PMR_DATA;
					end
				end
				PMR_DATA: begin
					if (phase_done) begin
						state <= PMR_TEND;
					end
				end
				PMR_TEND: begin
					state <= PMR_IDLE;
				end
				default: begin
					state <= PMR_IDLE;
				end
			endcase
		end
	end

	// ********************************************************
	// local status
	// ********************************************************
	// status follows termination, loading, transaction, termination
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			local_master_state_o <= PMR_ST_TERM;
		end else if (state == PMR_GRANT && req_on && !gntn_i) begin
			local_master_state_o <= PMR_ST_LOAD;
		end else if (state == PMR_LOAD) begin
			local_master_state_o <= PMR_ST_XFER;
		end else if (phase_done) begin
			local_master_state_o <= PMR_ST_TERM;
		end
	end

	// termination reason, cleared when a new transaction loads
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			local_term_reason_o <= PMR_TERM_NONE;
		end else if (state == PMR_LOAD) begin
			local_term_reason_o <= PMR_TERM_NONE;
		end else if (phase_done) begin
			local_term_reason_o <= PMR_TERM_NORMAL;
		end
	end

	// latch address, command and length
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			req_lat <= '0;
		end else if (state == PMR_GRANT && req_on && !gntn_i) begin
			req_lat.addr <= local_addr_data_in_i;
			req_lat.cmd <= local_cmd_byteen_in_i;
			req_lat.len <= PMR_LEN_W'(local_burst_len_in_i);
		end
	end

	// byte enables sampled in the address phase
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			byteen <= '0;
		end else if (state == PMR_ADDR) begin
			byteen <= local_cmd_byteen_in_i;
		end
	end

	// burst counter: loaded in address phase, counts done phases
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			local_burst_counter_o <= '0;
		end else if (state == PMR_LOAD) begin
			local_burst_counter_o <= LEN_W'(req_lat.len);
		end else if (phase_done && local_burst_counter_o != '0) begin
			local_burst_counter_o <= local_burst_counter_o - 1'b1;
		end
	end

	// ********************************************************
	// arbitration
	// ********************************************************
	// reqn asserted after a request, dropped once frame is out
	// and the local request has gone
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			reqn_o <= 1'b1;
		end else if (state == PMR_IDLE && req_on) begin
			reqn_o <= 1'b0;
		end else if (framen_oe_o && !framen_o && !req_on) begin
			reqn_o <= 1'b1;
		end else if (state == PMR_TEND && !req_on) begin
			reqn_o <= 1'b1;
		end
	end

	// local grant asserted on pci grant with the bus idle, then dropped once the pci grant goes
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			local_grant_n_o <= 1'b1;
		end else if (state == PMR_REQ) begin
			local_grant_n_o <= ~(~gntn_i & bus_idle);
		end else if (state == PMR_IDLE) begin
			local_grant_n_o <= 1'b1;
		end else begin
			local_grant_n_o <= local_grant_n_o | gntn_i;
		end
	end

	// ********************************************************
	// pci pin drive
	// ********************************************************
	// frame: asserted in address phase, raised with irdyn
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			framen_o <= 1'b1;
			framen_oe_o <= 1'b0;
		end else if (state == PMR_LOAD) begin
			framen_o <= 1'b0;
			framen_oe_o <= 1'b1;
		end else if (state == PMR_TURN && ready_on && fifo_ready) begin
			framen_o <= 1'b1;
		end else if (phase_done) begin
			framen_oe_o <= 1'b0;
		end
	end

	// irdy: driven high once owning, low when ready, released last
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			irdyn_o <= 1'b1;
			irdyn_oe_o <= 1'b0;
		end else if (state == PMR_LOAD) begin
			irdyn_o <= 1'b1;
			irdyn_oe_o <= 1'b1;
		end else if (state == PMR_TURN && ready_on && fifo_ready) begin
			irdyn_o <= 1'b0;
		end else if (phase_done) begin
			irdyn_o <= 1'b1;
		end else if (state == PMR_TEND) begin
			irdyn_oe_o <= 1'b0;
		end
	end

	// address/data lines: address phase only, floated for read
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			ad_o <= '0;
			ad_oe_o <= 1'b0;
		end else if (state == PMR_LOAD) begin
			ad_o <= req_lat.addr;
			ad_oe_o <= 1'b1;
		end else begin
			ad_oe_o <= 1'b0;
		end
	end

	// command then byte enables, released after the last phase
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			cben_o <= '0;
			cben_oe_o <= 1'b0;
		end else if (state == PMR_LOAD) begin
			cben_o <= req_lat.cmd;
			cben_oe_o <= 1'b1;
		end else if (state == PMR_ADDR) begin
			cben_o <= local_cmd_byteen_in_i;
		end else if (state == PMR_TURN) begin
			cben_o <= byteen;
		end else if (phase_done) begin
			cben_oe_o <= 1'b0;
		end
	end

	// ********************************************************
	// read data path
	// ********************************************************
	// word taken on the completing edge, shown the next clock;
	// the strobe pops it while the local master stays ready
	pmr_fifo #(
		.WIDTH(PMR_AD_W),
		.DEPTH(DEPTH)
	) u_fifo (
		.clk_sys_i(clk_sys_i),
		.rst_i(rst_i),
		.in_valid_i(phase_done),
		.in_ready_o(fifo_ready),
		.in_data_i(ad_i),
		.out_valid_o(fifo_valid),
		.out_ready_i(ready_on),
		.out_data_o(local_read_bus_out_o)
	);

	// strobe low while a word waits and local ready is asserted
	assign local_xfer_strobe_n_o = ~(fifo_valid & ready_on);
endmodule

// ---- verification/pmr_checker.sv ----
// concurrent checks on the ports of the single-word pci read master
// assumes the pins are resolved outside and reset is async active high
`timescale 1ns/10ps

// ************************************************************
// port checker
// ************************************************************
module pmr_checker
	import pmr_pkg::*;
#(
	parameter int LEN_W = PMR_LEN_W
) (
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic local_req_single_width_n_i,
	input wire logic [PMR_CBE_W-1:0] local_cmd_byteen_in_i,
	input wire logic [LEN_W-1:0] local_burst_len_in_i,
	input wire logic local_master_ready_n_i,
	input wire logic local_grant_n_o,
	input wire logic [3:0] local_master_state_o,
	input wire logic [1:0] local_term_reason_o,
	input wire logic [LEN_W-1:0] local_burst_counter_o,
	input wire logic local_xfer_strobe_n_o,
	input wire logic reqn_o,
	input wire logic gntn_i,
	input wire logic framen_i,
	input wire logic framen_o,
	input wire logic framen_oe_o,
	input wire logic irdyn_i,
	input wire logic irdyn_o,
	input wire logic irdyn_oe_o,
	input wire logic trdyn_i,
	input wire logic ad_oe_o,
	input wire logic [PMR_CBE_W-1:0] cben_o,
	input wire logic cben_oe_o
);
	// one clock domain, reset kills every attempt
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (rst_i);

	a_reqn_on_request: assert property (
		(!local_req_single_width_n_i && reqn_o && !irdyn_oe_o &&
		local_master_state_o == PMR_ST_TERM) |=> !reqn_o)
		else $error("reqn not asserted after request");
	a_local_grant: assert property (
		(!gntn_i && framen_i && irdyn_i && !reqn_o &&
		local_master_state_o == PMR_ST_TERM) |=> !local_grant_n_o)
		else $error("local grant missing");
	a_load_state: assert property (
		(!local_req_single_width_n_i && !gntn_i && !local_grant_n_o &&
		local_master_state_o == PMR_ST_TERM)
		|=> local_master_state_o == PMR_ST_LOAD)
		else $error("address loading not entered");
	a_address_phase: assert property (
		local_master_state_o == PMR_ST_LOAD |=>
		(local_master_state_o == PMR_ST_XFER && !framen_o && framen_oe_o &&
		ad_oe_o && cben_oe_o &&
		local_burst_counter_o == $past(local_burst_len_in_i, 2)))
		else $error("address phase wrong");
	a_reqn_release: assert property (
		(!framen_i && local_req_single_width_n_i && !reqn_o) |=> reqn_o)
		else $error("reqn held too long");
	a_turn_float: assert property (
		(framen_oe_o && !framen_o && ad_oe_o) |=> (!ad_oe_o && cben_oe_o &&
		cben_o == $past(local_cmd_byteen_in_i)))
		else $error("turnaround wrong");
	a_irdy_ready: assert property (
		$fell(irdyn_o) |-> !$past(local_master_ready_n_i))
		else $error("irdyn without local ready");
	a_irdy_frame: assert property (
		$fell(irdyn_o) |-> (framen_o && framen_oe_o && irdyn_oe_o))
		else $error("framen not raised with irdyn");
	a_phase_complete: assert property (
		(!irdyn_i && !trdyn_i && irdyn_oe_o) |=>
		(local_master_state_o == PMR_ST_TERM && !framen_oe_o && irdyn_o &&
		local_term_reason_o == PMR_TERM_NORMAL && !cben_oe_o &&
		local_burst_counter_o + 1'b1 == $past(local_burst_counter_o)))
		else $error("completion wrong");
	a_idle_release: assert property (
		$fell(cben_oe_o) |=> !irdyn_oe_o)
		else $error("irdyn not released");

	// main scenarios reached
	c_load: cover property (local_master_state_o == PMR_ST_LOAD);
	c_strobe: cover property (!local_xfer_strobe_n_o);
	c_stall: cover property (framen_oe_o && irdyn_o && local_master_ready_n_i);
endmodule

bind pmr_master pmr_checker #(.LEN_W(LEN_W)) u_chk (.clk_sys_i, .rst_i,
	.local_req_single_width_n_i, .local_cmd_byteen_in_i,
	.local_burst_len_in_i, .local_master_ready_n_i, .local_grant_n_o,
	.local_master_state_o, .local_term_reason_o, .local_burst_counter_o,
	.local_xfer_strobe_n_o, .reqn_o, .gntn_i, .framen_i, .framen_o,
	.framen_oe_o, .irdyn_i, .irdyn_o, .irdyn_oe_o, .trdyn_i, .ad_oe_o,
	.cben_o, .cben_oe_o);

// ---- verification/pmr_bus_partner.sv ----
// arbiter and addressed target model for the pci read master
// assumes resolved framen / irdyn levels from the bench
`timescale 1ns/10ps

module pmr_bus_partner
	import pmr_pkg::*;
(
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic reqn_i,
	input wire logic framen_i,
	input wire logic irdyn_i,
	input wire logic [PMR_AD_W-1:0] word_i,
	input wire logic [3:0] wait_i,
	output logic gntn_o,
	output logic devseln_o,
	output logic trdyn_o,
	output logic [PMR_AD_W-1:0] ad_o
);
	logic frame_d; // framen one clock ago
	logic [3:0] cnt; // wait clocks left before trdyn
	logic [PMR_AD_W-1:0] noise; // shown on ad while the target is off it

	// arbiter: grant follows the request one clock later
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) gntn_o <= 1'b1;
		else gntn_o <= reqn_i;
	end

	// target: claim on framen fall, data after the wait, then let go
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			frame_d <= 1'b1;
			devseln_o <= 1'b1;
			trdyn_o <= 1'b1;
			cnt <= 4'h0;
			noise <= 32'h0;
		end else begin
			frame_d <= framen_i;
			noise <= noise + 32'h9e37_79b9;
			if (!framen_i && frame_d) begin
				devseln_o <= 1'b0;
				cnt <= wait_i;
			end else if (!trdyn_o && !irdyn_i) begin
				trdyn_o <= 1'b1;
				devseln_o <= 1'b1;
			end else if (!devseln_o && trdyn_o) begin
				if (cnt == 4'h0) trdyn_o <= 1'b0;
				else cnt <= cnt - 4'h1;
			end
		end
	end

	// word only while trdyn is low, a changing pattern otherwise
	assign ad_o = !trdyn_o ? word_i : noise;
endmodule

// ---- verification/pci_master_single_read_32_test.sv ----
// self-checking bench for the single-word pci read master
// assumes the partner model on the pci side and pull-ups on framen/irdyn
`timescale 1ns/10ps

module pci_master_single_read_32_test
	import pmr_pkg::*;
();
	logic clk_sys_i, rst_i, local_req_single_width_n_i, local_master_ready_n_i;
	logic [PMR_AD_W-1:0] local_addr_data_in_i, local_read_bus_out_o, ad_i;
	logic [PMR_AD_W-1:0] ad_o, tgt_ad, tgt_word;
	logic [PMR_CBE_W-1:0] local_cmd_byteen_in_i, cben_o;
	logic [7:0] local_burst_len_in_i, local_burst_counter_o;
	logic [3:0] local_master_state_o, tgt_wait;
	logic [1:0] local_term_reason_o;
	logic local_grant_n_o, local_xfer_strobe_n_o, reqn_o, gntn_i, framen_i;
	logic framen_o, framen_oe_o, irdyn_i, irdyn_o, irdyn_oe_o, trdyn_i;
	logic devseln_i, ad_oe_o, cben_oe_o;
	int errors, compares, cycles;

	// ********************************************************
	// design, partner and wire resolution
	// ********************************************************
	pmr_master u_dut (.clk_sys_i, .rst_i, .local_req_single_width_n_i,
		.local_addr_data_in_i, .local_cmd_byteen_in_i, .local_burst_len_in_i,
		.local_master_ready_n_i, .local_grant_n_o, .local_master_state_o,
		.local_term_reason_o, .local_burst_counter_o, .local_read_bus_out_o,
		.local_xfer_strobe_n_o, .reqn_o, .gntn_i, .framen_i, .framen_o,
		.framen_oe_o, .irdyn_i, .irdyn_o, .irdyn_oe_o, .trdyn_i, .devseln_i,
		.ad_i, .ad_o, .ad_oe_o, .cben_o, .cben_oe_o);
	pmr_bus_partner u_bus (.clk_sys_i, .rst_i, .reqn_i(reqn_o), .framen_i,
		.irdyn_i, .word_i(tgt_word), .wait_i(tgt_wait), .gntn_o(gntn_i),
		.devseln_o(devseln_i), .trdyn_o(trdyn_i), .ad_o(tgt_ad));
	assign framen_i = framen_oe_o ? framen_o : 1'b1; // pull-up when released
	assign irdyn_i = irdyn_oe_o ? irdyn_o : 1'b1;
	assign ad_i = ad_oe_o ? ad_o : tgt_ad;

	// clock and hang guard
	initial begin
		clk_sys_i = 1'b0;
		forever #50 clk_sys_i = ~clk_sys_i;
	end
	always @(posedge clk_sys_i) begin
		cycles++;
		if (cycles == 2000) begin
			errors++;
			$display("[FAIL] %0t run hung", $time);
			summarize();
		end
	end

	// ********************************************************
	// shared tasks
	// ********************************************************
	task automatic check(input logic ok, input string msg);
		compares++;
		if (!ok) begin
			errors++;
			$display("[FAIL] %0t %s", $time, msg);
		end
	endtask

	task automatic summarize();
		$display("compares %0d errors %0d", compares, errors);
		if (errors == 0 && compares > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// one read as the local master; late stalls ready, park holds the word
	task automatic do_read(input logic [31:0] a, input logic [7:0] len,
		input logic [31:0] w, input logic [3:0] wt, input int late,
		input int park);
		int n;
		n = 0;
		local_req_single_width_n_i <= 1'b0;
		local_addr_data_in_i <= a;
		local_cmd_byteen_in_i <= 4'h6;
		local_burst_len_in_i <= len;
		tgt_word <= w;
		tgt_wait <= wt;
		do begin
			@(posedge clk_sys_i);
			n++;
		end while (local_master_state_o !== PMR_ST_LOAD && n < 20);
		check(local_master_state_o === PMR_ST_LOAD,
			"address loading missing");
		local_req_single_width_n_i <= 1'b1;
		local_cmd_byteen_in_i <= 4'hc;
		local_master_ready_n_i <= (late == 0) ? 1'b0 : 1'b1;
		@(posedge clk_sys_i);
		check(local_master_state_o === PMR_ST_XFER && framen_i === 1'b0 &&
			ad_i === a && cben_o === 4'h6 && local_burst_counter_o === len,
			"address phase wrong");
		repeat (late) begin
			@(posedge clk_sys_i);
			check(irdyn_i === 1'b1 && framen_i === 1'b0, "irdyn early");
		end
		local_master_ready_n_i <= 1'b0;
		n = 0;
		do begin
			@(posedge clk_sys_i);
			n++;
		end while (irdyn_i !== 1'b0 && n < 20);
		check(framen_i === 1'b1 && ad_oe_o === 1'b0 && cben_o === 4'hc &&
			reqn_o === 1'b1 && irdyn_i === 1'b0,
			"turnaround wrong");
		if (park > 0) begin
			local_master_ready_n_i <= 1'b1;
			repeat (park) @(posedge clk_sys_i);
			check(local_xfer_strobe_n_o === 1'b1, "strobe without ready");
			local_master_ready_n_i <= 1'b0;
		end
		n = 0;
		do begin
			@(posedge clk_sys_i);
			n++;
		end while (local_xfer_strobe_n_o !== 1'b0 && n < 20);
		check(local_read_bus_out_o === w && local_xfer_strobe_n_o === 1'b0,
			"read word wrong");
		check(local_master_state_o === PMR_ST_TERM && cben_oe_o === 1'b0 &&
			local_term_reason_o === PMR_TERM_NORMAL &&
			local_burst_counter_o === len - 8'h01, "end state wrong");
		local_master_ready_n_i <= 1'b1;
		@(posedge clk_sys_i);
		check(irdyn_oe_o === 1'b0 && local_xfer_strobe_n_o === 1'b1 &&
			local_grant_n_o === 1'b1, "idle release wrong");
	endtask

	// ********************************************************
	// scenarios
	// ********************************************************
	task automatic t_reset();
		check(reqn_o === 1'b1 && local_grant_n_o === 1'b1 &&
			local_master_state_o === PMR_ST_TERM && framen_oe_o === 1'b0 &&
			local_term_reason_o === PMR_TERM_NONE && irdyn_oe_o === 1'b0 &&
			local_burst_counter_o === 8'h00 && ad_oe_o === 1'b0 &&
			cben_oe_o === 1'b0 &&
			local_xfer_strobe_n_o === 1'b1, "reset values wrong");
		$display("test reset done");
	endtask

	task automatic t_plain();
		do_read(32'h0000_1000, 8'h01, 32'ha5c3_0f01, 4'h0, 0, 0);
		$display("test plain done");
	endtask

	task automatic t_slow_target();
		do_read(32'h0000_2004, 8'h01, 32'h5a3c_f0e1, 4'h3, 0, 0);
		$display("test slow target done");
	endtask

	task automatic t_late_ready();
		do_read(32'hffff_fffc, 8'h01, 32'h0123_4567, 4'h0, 4, 0);
		$display("test late ready done");
	endtask

	task automatic t_parked_word();
		do_read(32'h0000_3008, 8'h03, 32'hdead_0001, 4'h0, 0, 3);
		$display("test parked word done");
	endtask

	task automatic t_back_to_back();
		do_read(32'h0000_4000, 8'hff, 32'h8000_0000, 4'h1, 0, 0);
		do_read(32'h0000_4004, 8'h01, 32'h0000_0001, 4'h0, 1, 0);
		$display("test back to back done");
	endtask

	// main sequence
	initial begin
		errors = 0;
		compares = 0;
		cycles = 0;
		rst_i = 1'b1;
		local_req_single_width_n_i = 1'b1;
		local_master_ready_n_i = 1'b1;
		local_addr_data_in_i = 32'h0;
		local_cmd_byteen_in_i = 4'h0;
		local_burst_len_in_i = 8'h00;
		tgt_word = 32'h0;
		tgt_wait = 4'h0;
		repeat (3) @(posedge clk_sys_i);
		rst_i <= 1'b0;
		@(posedge clk_sys_i);
		t_reset();
		t_plain();
		t_slow_target();
		t_late_ready();
		t_parked_word();
		t_back_to_back();
		summarize();
	end
endmodule
